// file: hw/ddcsc_pkg.sv
package ddcsc_pkg;

   // Register offsets of the control group.
   localparam logic [8:0] ADDR_SYNC   = 9'h100;
   localparam logic [8:0] ADDR_MIX    = 9'h101;
   localparam logic [8:0] ADDR_FIR    = 9'h102;
   localparam logic [8:0] ADDR_HBF    = 9'h103;
   localparam logic [8:0] ADDR_ODET   = 9'h104;
   localparam logic [8:0] ADDR_COARSE = 9'h105;
   localparam logic [8:0] ADDR_FHI_L  = 9'h106;
   localparam logic [8:0] ADDR_FHI_H  = 9'h107;
   localparam logic [8:0] ADDR_FLO_L  = 9'h108;
   localparam logic [8:0] ADDR_FLO_H  = 9'h109;
   localparam logic [8:0] ADDR_DWL_L  = 9'h10a;
   localparam logic [8:0] ADDR_DWL_H  = 9'h10b;
   localparam logic [8:0] ADDR_DC     = 9'h10c;
   localparam logic [8:0] ADDR_DCV_L  = 9'h10d;
   localparam logic [8:0] ADDR_DCV_H  = 9'h10e;

   // Bit positions in the sync gating register.
   localparam int SY_MASTER   = 0;
   localparam int SY_DIV_EN   = 1;
   localparam int SY_DIV_ONE  = 2;
   localparam int SY_OSC_EN   = 3;
   localparam int SY_OSC_ONE  = 4;
   localparam int SY_HB_EN    = 5;
   localparam int SY_HB_ONE   = 6;
   localparam int SY_MON_EN   = 7;

   // Bit positions in the mixer, filter, detect and dc registers.
   localparam int MX_EN       = 0;
   localparam int MX_ONE      = 1;
   localparam int MX_ST_LO    = 4;
   localparam int FI_EN       = 0;
   localparam int FI_CPLX     = 1;
   localparam int FI_MIXDIS   = 2;
   localparam int FI_GAIN1    = 3;
   localparam int HB_HIPASS   = 1;
   localparam int HB_REV      = 2;
   localparam int HB_PHASE    = 3;
   localparam int OD_EN       = 0;
   localparam int DC_MON_EN   = 0;
   localparam int DC_PATH_EN  = 1;
   localparam int DC_BW_LO    = 2;
   localparam int DC_FREEZE   = 6;

   // Writable masks; reserved bits read as zero, except half-band bit 0 which reads one.
   localparam logic [7:0] MASK_MIX    = 8'h33;
   localparam logic [7:0] MASK_FIR    = 8'h0f;
   localparam logic [7:0] MASK_HBF    = 8'h0e;
   localparam logic [7:0] MASK_ODET   = 8'h0f;
   localparam logic [7:0] MASK_COARSE = 8'h07;
   localparam logic [7:0] MASK_HI5    = 8'h1f;
   localparam logic [7:0] MASK_DC     = 8'h7f;
   localparam logic [7:0] HBF_RSVD1   = 8'h01;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [3:0] DC_BW_MAX   = 4'hd;
   localparam logic [3:0] DC_BW_BASE  = 4'he;

   // Register access request from the serial control port.
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [8:0] addr;
      logic [7:0] wdata;
   } ddcsc_req_type;

   // Decoded control outputs towards the datapath.
   typedef struct packed
   {
      logic       fir_en;
      logic       fir_gain_one;
      logic       cplx_en;
      logic       mix_dis;
      logic       hb_phase;
      logic       hb_hipass;
      logic       hb_rev;
      logic [2:0] od_mode;
      logic [2:0] coarse_lim;
      logic       dc_mon_en;
      logic       dc_path_en;
      logic [3:0] dc_bw_k;
   } ddcsc_ctl_type;

endpackage : ddcsc_pkg

// file: hw/ddcsc_regs.sv
// Summary of operation
// R1 - No sync pulse reaches any destination unless the master enable is set.
// R2 - Monitor gets every sync while monitor and master enables are set.
// R3 - Half-band one-shot mode takes first sync then clears half-band enable.
// R4 - Passed half-band sync restarts the decimator at the selected phase.
// R5 - Oscillator one-shot mode takes first sync then clears oscillator enable.
// R6 - Passed oscillator sync restarts the oscillator loading the phase offset.
// R7 - Divider one-shot mode takes first sync then clears divider enable.
// R8 - Divider gets every sync while divider and master enables are set.
// R9 - Mixer starts at the phase in the two-bit start state field.
// R10 - Mixer one-shot mode takes first sync then clears the mixer enable.
// R11 - Mixer gets sync pulses while mixer and master enables are set.
// R12 - FIR gain is one when the gain bit is high, two when low.
// R13 - Host sets complex output together with the mixer disable bit.
// R14 - FIR runs when enabled, otherwise bypassed and powered down.
// R15 - Half-band phase bit selects the alternate decimation phase.
// R16 - High-pass select, spectral reversal bit; reserved bit 0 reads one.
// R17 - Detect outputs float when disabled or both interleaved channels are off.
// R18 - Upper flag set when magnitude exceeds the fine upper threshold.
// R19 - Lower condition when magnitude is below the fine lower threshold.
// R20 - Lower and gain-raise flags assert after the dwell count below threshold.
// R21 - Freeze holds the last dc value given to the monitor.
// R22 - Bandwidth field values fourteen and fifteen act as thirteen.
// R23 - A one-shot enable clears in the same cycle its sync is applied.
`timescale 1ns/1ps
`default_nettype none
module ddcsc_regs
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire ddcsc_pkg::ddcsc_req_type req,
   output logic                  [7:0]  rdata,
   input  wire logic                    sync_in,
   input  wire logic            [12:0]  mag_a,
   input  wire logic            [12:0]  mag_b,
   input  wire logic                    chan_a_on,
   input  wire logic                    chan_b_on,
   input  wire logic                    lvds_interleave,
   input  wire logic            [13:0]  dc_calc_a,
   output logic                         sync_mon,
   output logic                         sync_hb,
   output logic                         sync_osc,
   output logic                         sync_div,
   output logic                         sync_mix,
   output logic                  [1:0]  mix_start_phase,
   output logic                 [15:0]  osc_phase_load,
   input  wire logic            [15:0]  osc_phase_offset,
   output ddcsc_pkg::ddcsc_ctl_type     ctl,
   output logic                  [1:0]  fine_above_flag,
   output logic                  [1:0]  fine_below_flag,
   output logic                  [1:0]  gain_raise_flag,
   output logic                         detect_oe,
   output logic                  [1:0]  overrange_detect_outputs,
   output logic                 [13:0]  dc_to_monitor
);

   logic [7:0]  sync_q;
   logic [7:0]  mix_q;
   logic [7:0]  fir_q;
   logic [7:0]  hbf_q;
   logic [7:0]  odet_q;
   logic [7:0]  coarse_q;
   logic [12:0] fhi_q;
   logic [12:0] flo_q;
   logic [15:0] dwell_q;
   logic [7:0]  dc_q;
   logic [13:0] dcv_q;
   logic [1:0]  above_q;
   logic [1:0]  below_q;
   logic [15:0] cnt_q [2];
   logic        master;
   logic        fire_hb;
   logic        fire_osc;
   logic        fire_div;
   logic        fire_mix;

   // Sync gating of each destination behind the master enable.
   assign master   = sync_in && sync_q[ddcsc_pkg::SY_MASTER]; // R1
   assign fire_hb  = master && sync_q[ddcsc_pkg::SY_HB_EN];
   assign fire_osc = master && sync_q[ddcsc_pkg::SY_OSC_EN];
   assign fire_div = master && sync_q[ddcsc_pkg::SY_DIV_EN];
   assign fire_mix = master && mix_q[ddcsc_pkg::MX_EN];

   // Registered sync strobes, one cycle after the pulse is taken.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sync_mon <= 1'b0;
         sync_hb  <= 1'b0;
         sync_osc <= 1'b0;
         sync_div <= 1'b0;
         sync_mix <= 1'b0;
      end
      else
      begin
         sync_mon <= master && sync_q[ddcsc_pkg::SY_MON_EN]; // R2
         sync_hb  <= fire_hb; // R4
         sync_osc <= fire_osc; // R6
         sync_div <= fire_div; // R8
         sync_mix <= fire_mix; // R11
      end
   end

   // Oscillator phase captured with its sync; mixer start state registered every cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         osc_phase_load  <= 16'h0000;
         mix_start_phase <= 2'h0;
      end
      else
      begin
         if (fire_osc)
            osc_phase_load <= osc_phase_offset; // R6
         mix_start_phase <= mix_q[ddcsc_pkg::MX_ST_LO +: 2]; // R9
      end
   end

   // Sync gating register; one-shot enables clear on their sync, which wins over a write.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sync_q <= ddcsc_pkg::RST_BYTE;
      else
      begin
         if (req.wr && req.addr == ddcsc_pkg::ADDR_SYNC)
            sync_q <= req.wdata;
         if (fire_hb && sync_q[ddcsc_pkg::SY_HB_ONE])
            sync_q[ddcsc_pkg::SY_HB_EN] <= 1'b0; // R3 R23
         if (fire_osc && sync_q[ddcsc_pkg::SY_OSC_ONE])
            sync_q[ddcsc_pkg::SY_OSC_EN] <= 1'b0; // R5 R23
         if (fire_div && sync_q[ddcsc_pkg::SY_DIV_ONE])
            sync_q[ddcsc_pkg::SY_DIV_EN] <= 1'b0; // R7 R23
      end
   end

   // Mixer control register; the mixer enable is the bit cleared in one-shot mode.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         mix_q <= ddcsc_pkg::RST_BYTE;
      else
      begin
         if (req.wr && req.addr == ddcsc_pkg::ADDR_MIX)
            mix_q <= req.wdata & ddcsc_pkg::MASK_MIX;
         if (fire_mix && mix_q[ddcsc_pkg::MX_ONE])
            mix_q[ddcsc_pkg::MX_EN] <= 1'b0; // R10 R23
      end
   end

   // Plain read-write control registers.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         fir_q    <= ddcsc_pkg::RST_BYTE;
         hbf_q    <= ddcsc_pkg::RST_BYTE;
         odet_q   <= ddcsc_pkg::RST_BYTE;
         coarse_q <= ddcsc_pkg::RST_BYTE;
         fhi_q    <= 13'h0000;
         flo_q    <= 13'h0000;
         dwell_q  <= 16'h0000;
         dc_q     <= ddcsc_pkg::RST_BYTE;
      end
      else if (req.wr)
      begin
         case (req.addr)
            ddcsc_pkg::ADDR_FIR:    fir_q    <= req.wdata & ddcsc_pkg::MASK_FIR;
            ddcsc_pkg::ADDR_HBF:    hbf_q    <= req.wdata & ddcsc_pkg::MASK_HBF;
            ddcsc_pkg::ADDR_ODET:   odet_q   <= req.wdata & ddcsc_pkg::MASK_ODET;
            ddcsc_pkg::ADDR_COARSE: coarse_q <= req.wdata & ddcsc_pkg::MASK_COARSE;
            ddcsc_pkg::ADDR_FHI_L:  fhi_q[7:0]   <= req.wdata;
            ddcsc_pkg::ADDR_FHI_H:  fhi_q[12:8]  <= req.wdata[4:0];
            ddcsc_pkg::ADDR_FLO_L:  flo_q[7:0]   <= req.wdata;
            ddcsc_pkg::ADDR_FLO_H:  flo_q[12:8]  <= req.wdata[4:0];
            ddcsc_pkg::ADDR_DWL_L:  dwell_q[7:0]  <= req.wdata;
            ddcsc_pkg::ADDR_DWL_H:  dwell_q[15:8] <= req.wdata;
            ddcsc_pkg::ADDR_DC:     dc_q     <= req.wdata & ddcsc_pkg::MASK_DC;
            default:                ;
         endcase
      end
   end

   // Datapath controls decoded from the registers.
   always_comb
   begin
      ctl.fir_en       = fir_q[ddcsc_pkg::FI_EN]; // R14
      ctl.fir_gain_one = fir_q[ddcsc_pkg::FI_GAIN1]; // R12
      ctl.cplx_en      = fir_q[ddcsc_pkg::FI_CPLX]; // R13
      ctl.mix_dis      = fir_q[ddcsc_pkg::FI_MIXDIS];
      ctl.hb_phase     = hbf_q[ddcsc_pkg::HB_PHASE]; // R15
      ctl.hb_hipass    = hbf_q[ddcsc_pkg::HB_HIPASS]; // R16
      ctl.hb_rev       = hbf_q[ddcsc_pkg::HB_REV]; // R16
      ctl.od_mode      = odet_q[3:1];
      ctl.coarse_lim   = coarse_q[2:0];
      ctl.dc_mon_en    = dc_q[ddcsc_pkg::DC_MON_EN];
      ctl.dc_path_en   = dc_q[ddcsc_pkg::DC_PATH_EN];
      if (dc_q[ddcsc_pkg::DC_BW_LO +: 4] >= ddcsc_pkg::DC_BW_BASE)
         ctl.dc_bw_k = ddcsc_pkg::DC_BW_MAX; // R22
      else
         ctl.dc_bw_k = dc_q[ddcsc_pkg::DC_BW_LO +: 4];
   end

   // Per-channel fine threshold comparison and dwell timing.
   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      logic [12:0] mag;
      assign mag = (c == 0) ? mag_a : mag_b;

      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            above_q[c] <= 1'b0;
            below_q[c] <= 1'b0;
            cnt_q[c]   <= 16'h0000;
         end
         else
         begin
            above_q[c] <= mag > fhi_q; // R18
            if (mag < flo_q) // R19
            begin
               if (cnt_q[c] != 16'hffff)
                  cnt_q[c] <= cnt_q[c] + 16'h0001;
               // A saturated count keeps the flag up, since the sum would otherwise wrap to zero.
               below_q[c] <= (cnt_q[c] == 16'hffff) || ((cnt_q[c] + 16'h0001) >= dwell_q); // R20
            end
            else
            begin
               cnt_q[c]   <= 16'h0000;
               below_q[c] <= 1'b0;
            end
         end
      end
   end

   assign fine_above_flag = above_q;
   assign fine_below_flag = below_q; // R20
   assign gain_raise_flag = below_q; // R20

   // Detect pin drive; a lone live channel feeds both pins in interleaved mode.
   always_comb
   begin
      overrange_detect_outputs = above_q;
      if (lvds_interleave)
      begin
         detect_oe = odet_q[ddcsc_pkg::OD_EN] && (chan_a_on || chan_b_on); // R17
         if (chan_a_on && !chan_b_on)
            overrange_detect_outputs = {above_q[0], above_q[0]}; // R17
         else if (chan_b_on && !chan_a_on)
            overrange_detect_outputs = {above_q[1], above_q[1]}; // R17
      end
      else
         detect_oe = odet_q[ddcsc_pkg::OD_EN]; // R17
   end

   // Dc value held while frozen.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         dcv_q <= 14'h0000;
      else if (!dc_q[ddcsc_pkg::DC_FREEZE])
         dcv_q <= dc_calc_a; // R21
   end

   assign dc_to_monitor = dcv_q;

   // Registered read data.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (req.rd)
      begin
         case (req.addr)
            ddcsc_pkg::ADDR_SYNC:   rdata <= sync_q;
            ddcsc_pkg::ADDR_MIX:    rdata <= mix_q;
            ddcsc_pkg::ADDR_FIR:    rdata <= fir_q;
            ddcsc_pkg::ADDR_HBF:    rdata <= hbf_q | ddcsc_pkg::HBF_RSVD1; // R16
            ddcsc_pkg::ADDR_ODET:   rdata <= odet_q;
            ddcsc_pkg::ADDR_COARSE: rdata <= coarse_q;
            ddcsc_pkg::ADDR_FHI_L:  rdata <= fhi_q[7:0];
            ddcsc_pkg::ADDR_FHI_H:  rdata <= {3'h0, fhi_q[12:8]};
            ddcsc_pkg::ADDR_FLO_L:  rdata <= flo_q[7:0];
            ddcsc_pkg::ADDR_FLO_H:  rdata <= {3'h0, flo_q[12:8]};
            ddcsc_pkg::ADDR_DWL_L:  rdata <= dwell_q[7:0];
            ddcsc_pkg::ADDR_DWL_H:  rdata <= dwell_q[15:8];
            ddcsc_pkg::ADDR_DC:     rdata <= dc_q;
            ddcsc_pkg::ADDR_DCV_L:  rdata <= dcv_q[7:0];
            ddcsc_pkg::ADDR_DCV_H:  rdata <= {2'h0, dcv_q[13:8]};
            default:                rdata <= 8'h00;
         endcase
      end
   end

   // Checks on sync gating, oscillator load, flag timing, dc freeze, bandwidth clamp and detect float.
   property p_no_master; // R1
      @(posedge clk_sys) disable iff (rst)
      !(sync_in && sync_q[ddcsc_pkg::SY_MASTER]) |=> !sync_mon && !sync_hb && !sync_osc && !sync_div && !sync_mix;
   endproperty
   a_no_master: assert property (p_no_master) else $error("sync passed without master enable"); // R1

   property p_mon; // R2
      @(posedge clk_sys) disable iff (rst)
      sync_in && sync_q[ddcsc_pkg::SY_MASTER] && sync_q[ddcsc_pkg::SY_MON_EN] |=> sync_mon;
   endproperty
   a_mon: assert property (p_mon) else $error("monitor sync lost"); // R2

   sequence s_hb_one;
      fire_hb && sync_q[ddcsc_pkg::SY_HB_ONE];
   endsequence
   property p_hb_one; // R3
      @(posedge clk_sys) disable iff (rst)
      s_hb_one |=> !sync_q[ddcsc_pkg::SY_HB_EN] ##1 !sync_hb;
   endproperty
   a_hb_one: assert property (p_hb_one) else $error("half-band one-shot did not clear"); // R3

   property p_osc_load; // R6
      @(posedge clk_sys) disable iff (rst)
      fire_osc |=> sync_osc && osc_phase_load == $past(osc_phase_offset);
   endproperty
   a_osc_load: assert property (p_osc_load) else $error("oscillator phase not loaded"); // R6

   property p_osc_one; // R5
      @(posedge clk_sys) disable iff (rst)
      fire_osc && sync_q[ddcsc_pkg::SY_OSC_ONE] |=> !sync_q[ddcsc_pkg::SY_OSC_EN];
   endproperty
   a_osc_one: assert property (p_osc_one) else $error("oscillator one-shot did not clear"); // R5

   property p_div_one; // R7
      @(posedge clk_sys) disable iff (rst)
      fire_div && sync_q[ddcsc_pkg::SY_DIV_ONE] |=> !sync_q[ddcsc_pkg::SY_DIV_EN];
   endproperty
   a_div_one: assert property (p_div_one) else $error("divider one-shot did not clear"); // R7

   property p_mix_one; // R10
      @(posedge clk_sys) disable iff (rst)
      fire_mix && mix_q[ddcsc_pkg::MX_ONE] |=> !mix_q[ddcsc_pkg::MX_EN];
   endproperty
   a_mix_one: assert property (p_mix_one) else $error("mixer one-shot did not clear"); // R10

   property p_above; // R18
      @(posedge clk_sys) disable iff (rst)
      mag_a > fhi_q |=> fine_above_flag[0];
   endproperty
   a_above: assert property (p_above) else $error("upper flag missing"); // R18

   property p_below_rise; // R20
      @(posedge clk_sys) disable iff (rst)
      $rose(fine_below_flag[0]) |-> $past(mag_a < flo_q) && gain_raise_flag[0];
   endproperty
   a_below_rise: assert property (p_below_rise) else $error("lower flag without lower signal"); // R20

   property p_freeze; // R21
      @(posedge clk_sys) disable iff (rst)
      dc_q[ddcsc_pkg::DC_FREEZE] ##1 dc_q[ddcsc_pkg::DC_FREEZE] |-> $stable(dc_to_monitor);
   endproperty
   a_freeze: assert property (p_freeze) else $error("dc value moved while frozen"); // R21

   property p_bw_clamp; // R22
      @(posedge clk_sys) disable iff (rst)
      dc_q[ddcsc_pkg::DC_BW_LO +: 4] >= ddcsc_pkg::DC_BW_BASE |-> ctl.dc_bw_k == ddcsc_pkg::DC_BW_MAX;
   endproperty
   a_bw_clamp: assert property (p_bw_clamp) else $error("bandwidth field not clamped"); // R22

   property p_float; // R17
      @(posedge clk_sys) disable iff (rst)
      !odet_q[ddcsc_pkg::OD_EN] || (lvds_interleave && !chan_a_on && !chan_b_on) |-> !detect_oe;
   endproperty
   a_float: assert property (p_float) else $error("detect pins driven while they should float"); // R17

   // The lower flag stays up while the magnitude stays below and the dwell is unchanged.
   property p_below_hold; // R20
      @(posedge clk_sys) disable iff (rst)
      fine_below_flag[0] && mag_a < flo_q && $stable(dwell_q) |=> fine_below_flag[0];
   endproperty
   a_below_hold: assert property (p_below_hold) else $error("lower flag dropped while still below"); // R20

endmodule : ddcsc_regs
`default_nettype wire

// file: sim/ddcsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddcsc_host
(
   input  wire logic                   clk_sys,
   output var ddcsc_pkg::ddcsc_req_type req,
   input  wire logic             [7:0] rdata
);

   // The bus idles from time zero so no strobe is seen during reset.
   initial req = '0;

   // Raises a one-cycle write strobe after an edge and drops it at the sampling edge.
   task automatic write_reg(input logic [8:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clk_sys);
      req <= '0;
   endtask : write_reg

   // Raises a one-cycle read strobe and takes the data once the sampling edge has landed.
   task automatic read_reg(input logic [8:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge clk_sys);
      req <= '0;
      #1;
      data = rdata;
   endtask : read_reg

   // Complex output is always asked for together with the mixer bypass.
   task automatic set_complex_out();
      write_reg(ddcsc_pkg::ADDR_FIR, 8'h06);
   endtask : set_complex_out

endmodule : ddcsc_host
`default_nettype wire

// file: sim/ddcsc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddcsc_regs_tb;

   logic                      clk_sys;
   logic                      rst;
   ddcsc_pkg::ddcsc_req_type  req;
   logic               [7:0]  rdata;
   logic                      sync_in;
   logic              [12:0]  mag_a;
   logic              [12:0]  mag_b;
   logic                      chan_a_on;
   logic                      chan_b_on;
   logic                      lvds_interleave;
   logic              [13:0]  dc_calc_a;
   logic                      sync_mon;
   logic                      sync_hb;
   logic                      sync_osc;
   logic                      sync_div;
   logic                      sync_mix;
   logic               [1:0]  mix_start_phase;
   logic              [15:0]  osc_phase_load;
   logic              [15:0]  osc_phase_offset;
   ddcsc_pkg::ddcsc_ctl_type  ctl;
   logic               [1:0]  fine_above_flag;
   logic               [1:0]  fine_below_flag;
   logic               [1:0]  gain_raise_flag;
   logic                      detect_oe;
   logic               [1:0]  overrange_detect_outputs;
   logic              [13:0]  dc_to_monitor;
   int                        num_errors;
   int                        checks_done;

   ddcsc_host i_host (.clk_sys(clk_sys), .req(req), .rdata(rdata));

   ddcsc_regs i_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .sync_in(sync_in),
      .mag_a(mag_a), .mag_b(mag_b), .chan_a_on(chan_a_on), .chan_b_on(chan_b_on),
      .lvds_interleave(lvds_interleave), .dc_calc_a(dc_calc_a), .sync_mon(sync_mon), .sync_hb(sync_hb),
      .sync_osc(sync_osc), .sync_div(sync_div), .sync_mix(sync_mix), .mix_start_phase(mix_start_phase),
      .osc_phase_load(osc_phase_load), .osc_phase_offset(osc_phase_offset), .ctl(ctl),
      .fine_above_flag(fine_above_flag), .fine_below_flag(fine_below_flag),
      .gain_raise_flag(gain_raise_flag), .detect_oe(detect_oe),
      .overrange_detect_outputs(overrange_detect_outputs), .dc_to_monitor(dc_to_monitor));

   // The clock toggles every half period of 5 ns.
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Compares one value with its expectation and counts the outcome.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask : chk

   // Reads one register and compares it.
   task automatic rd_chk(input logic [8:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      i_host.read_reg(addr, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask : rd_chk

   // Writes one register and reads it back.
   task automatic wr_rd(input logic [8:0] addr, input logic [7:0] wd, input logic [7:0] exp);
      i_host.write_reg(addr, wd);
      rd_chk(addr, exp);
   endtask : wr_rd

   // Holds the sync input high for two cycles and checks the strobes after each.
   task automatic pulse2(input logic [4:0] e1, input logic [4:0] e2);
      @(posedge clk_sys) sync_in <= 1'b1;
      @(posedge clk_sys);
      #1 chk({sync_mon, sync_hb, sync_osc, sync_div, sync_mix}, e1);
      @(posedge clk_sys) sync_in <= 1'b0;
      #1 chk({sync_mon, sync_hb, sync_osc, sync_div, sync_mix}, e2);
   endtask : pulse2

   // Lets a number of clock edges pass and settles after the last.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   // Cuts a hung run short.
   initial
   begin
      #300us;
      num_errors++;
      report_and_stop();
   end

   // Main sequence of tests.
   initial
   begin
      num_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      sync_in = 1'b0;
      mag_a = 13'h1001;
      mag_b = 13'h0000;
      chan_a_on = 1'b1;
      chan_b_on = 1'b1;
      lvds_interleave = 1'b0;
      dc_calc_a = 14'h2a5c;
      osc_phase_offset = 16'h1234;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (logic [8:0] a = 9'h100; a <= 9'h10c; a++)
         rd_chk(a, (a == ddcsc_pkg::ADDR_HBF) ? 8'h01 : 8'h00);
      wr_rd(ddcsc_pkg::ADDR_SYNC, 8'hff, 8'hff);
      wr_rd(ddcsc_pkg::ADDR_MIX, 8'hff, 8'h33);
      wr_rd(ddcsc_pkg::ADDR_FIR, 8'hff, 8'h0f);
      wr_rd(ddcsc_pkg::ADDR_HBF, 8'hff, 8'h0f);
      wr_rd(ddcsc_pkg::ADDR_ODET, 8'hff, 8'h0f);
      wr_rd(ddcsc_pkg::ADDR_COARSE, 8'hff, 8'h07);
      wr_rd(ddcsc_pkg::ADDR_FHI_L, 8'hff, 8'hff);
      wr_rd(ddcsc_pkg::ADDR_FHI_H, 8'hff, 8'h1f);
      wr_rd(ddcsc_pkg::ADDR_FLO_L, 8'hff, 8'hff);
      wr_rd(ddcsc_pkg::ADDR_FLO_H, 8'hff, 8'h1f);
      wr_rd(ddcsc_pkg::ADDR_DWL_L, 8'hff, 8'hff);
      wr_rd(ddcsc_pkg::ADDR_DWL_H, 8'hff, 8'hff);
      wr_rd(ddcsc_pkg::ADDR_DC, 8'hff, 8'h7f);
      wr_rd(ddcsc_pkg::ADDR_DCV_L, 8'hff, 8'h5c);
      rd_chk(ddcsc_pkg::ADDR_DCV_H, 8'h2a);
      wr_rd(9'h111, 8'hff, 8'h00);
      wr_rd(9'h0ff, 8'hff, 8'h00);
      chk({ctl.fir_en, ctl.fir_gain_one, ctl.cplx_en, ctl.mix_dis}, 4'hf);
      chk({ctl.hb_phase, ctl.hb_hipass, ctl.hb_rev, ctl.od_mode, ctl.coarse_lim}, 9'h1ff);
      chk({ctl.dc_mon_en, ctl.dc_path_en, ctl.dc_bw_k}, 6'h3d);
      chk(mix_start_phase, 2'b11);
      i_host.write_reg(ddcsc_pkg::ADDR_FIR, 8'h08);
      i_host.write_reg(ddcsc_pkg::ADDR_DC, 8'h38);
      i_host.write_reg(ddcsc_pkg::ADDR_MIX, 8'h20);
      i_host.write_reg(ddcsc_pkg::ADDR_HBF, 8'h08);
      #1 chk({ctl.fir_en, ctl.fir_gain_one, ctl.hb_phase, ctl.hb_hipass, ctl.hb_rev}, 5'b01100);
      chk(ctl.dc_bw_k, 4'hd);
      chk(mix_start_phase, 2'b10);
      i_host.write_reg(ddcsc_pkg::ADDR_DC, 8'h14);
      i_host.set_complex_out();
      #1 chk({ctl.dc_mon_en, ctl.dc_path_en, ctl.dc_bw_k}, 6'h05);
      chk({ctl.fir_en, ctl.cplx_en, ctl.mix_dis}, 3'b011);
      // Sync gating: master off, then continuous, then one-shot with back-to-back pulses.
      i_host.write_reg(ddcsc_pkg::ADDR_MIX, 8'h01);
      i_host.write_reg(ddcsc_pkg::ADDR_SYNC, 8'hbe);
      pulse2(5'h00, 5'h00);
      i_host.write_reg(ddcsc_pkg::ADDR_SYNC, 8'hab);
      pulse2(5'h1f, 5'h1f);
      chk(osc_phase_load, 16'h1234);
      i_host.write_reg(ddcsc_pkg::ADDR_MIX, 8'h03);
      i_host.write_reg(ddcsc_pkg::ADDR_SYNC, 8'h7f);
      pulse2(5'h0f, 5'h00);
      rd_chk(ddcsc_pkg::ADDR_SYNC, 8'h55);
      rd_chk(ddcsc_pkg::ADDR_MIX, 8'h02);
      // Fine thresholds: upper 0x1000, lower 0x0100, dwell of five cycles.
      i_host.write_reg(ddcsc_pkg::ADDR_FHI_L, 8'h00);
      i_host.write_reg(ddcsc_pkg::ADDR_FHI_H, 8'h10);
      i_host.write_reg(ddcsc_pkg::ADDR_FLO_L, 8'h00);
      i_host.write_reg(ddcsc_pkg::ADDR_FLO_H, 8'h01);
      i_host.write_reg(ddcsc_pkg::ADDR_DWL_L, 8'h05);
      i_host.write_reg(ddcsc_pkg::ADDR_DWL_H, 8'h00);
      i_host.write_reg(ddcsc_pkg::ADDR_ODET, 8'h01);
      @(posedge clk_sys) mag_b <= 13'h1fff;
      cyc(2);
      chk({detect_oe, fine_above_flag, overrange_detect_outputs}, 5'h1f);
      @(posedge clk_sys) mag_a <= 13'h1000;
      cyc(2);
      chk(fine_above_flag, 2'b10);
      @(posedge clk_sys) mag_a <= 13'h00ff;
      for (int i = 1; i <= 5; i++)
      begin
         cyc(1);
         chk({fine_below_flag, gain_raise_flag}, (i == 5) ? 4'b0101 : 4'b0000);
      end
      @(posedge clk_sys) mag_a <= 13'h0100;
      cyc(2);
      chk({fine_below_flag, gain_raise_flag}, 4'h0);
      // Interleaved outputs repeat the live channel, and float once both are off.
      @(posedge clk_sys)
      begin
         lvds_interleave <= 1'b1;
         chan_a_on <= 1'b0;
      end
      cyc(2);
      chk({detect_oe, overrange_detect_outputs}, 3'b111);
      @(posedge clk_sys)
      begin
         chan_a_on <= 1'b1;
         chan_b_on <= 1'b0;
      end
      cyc(2);
      chk({detect_oe, overrange_detect_outputs}, 3'b100);
      @(posedge clk_sys) chan_a_on <= 1'b0;
      cyc(2);
      chk(detect_oe, 1'b0);
      @(posedge clk_sys)
      begin
         lvds_interleave <= 1'b0;
         chan_a_on <= 1'b1;
         chan_b_on <= 1'b1;
      end
      i_host.write_reg(ddcsc_pkg::ADDR_ODET, 8'h00);
      cyc(1);
      chk(detect_oe, 1'b0);
      // Freeze holds the value given to the monitor while the computed one moves.
      i_host.write_reg(ddcsc_pkg::ADDR_DC, 8'h40);
      @(posedge clk_sys) dc_calc_a <= 14'h1111;
      cyc(3);
      chk(dc_to_monitor, 14'h2a5c);
      i_host.write_reg(ddcsc_pkg::ADDR_DC, 8'h00);
      cyc(2);
      chk(dc_to_monitor, 14'h1111);
      report_and_stop();
   end

endmodule : ddcsc_regs_tb
`default_nettype wire
